// [dar_top.sv]
// Purpose: Two alarm channels, shared bypass, latch, failsafe, analog output test
// Assumes: Reading, supply indications and button synchronous to clk
// Notes:   Registers over AHB-Lite, zero wait states, OKAY always
//
// What this block does
// - Two independent alarm channels per reading
// - Setpoint above output range is rejected
// - One percent of range hysteresis band
// - Delay zero to 300 minutes before trigger
// - Bit chooses contact open or closed
// - Bit chooses above or below trigger
// - Readable status bit per alarm
// - One shared bypass setting
// - Bypass timer suppresses channel alarms and measured output
// - Non-latching contacts follow the condition
// - Latching contacts hold after return
// - Button held one second releases latch
// - Failsafe triggers both on low supply
// - Failsafe holds until supply above 12V
// - Non-failsafe ignores low supply
// - Zero test drives zero word, steps adjust
// - Span test drives span word, steps adjust
// - Mid test drives zero/span midpoint
//
// Added by the designer: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
module dar_top
#(
  parameter longint unsigned MIN_CYCLES  = dar_pkg::MIN_CYC,
  parameter int unsigned     HOLD_CYCLES = dar_pkg::HOLD_CYC
)(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire dar_pkg::dar_in_t  pins_i,
  output var  dar_pkg::dar_out_t pins_o
);
  import dar_pkg::*;
  // Minute counters are 33 bits wide
  if (MIN_CYCLES < 1 || MIN_CYCLES > 64'h1_ffff_ffff || HOLD_CYCLES < 1)
  begin : g_bad_timing
    $error("Timing counts do not fit the counters");
  end

  typedef struct packed {
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [5:0]  ctrl;
    logic [15:0] range;
    logic [15:0] sp1;
    logic [15:0] sp2;
    logic [8:0]  dly1;
    logic [8:0]  dly2;
    logic [6:0]  byp;
    logic [15:0] zero;
    logic [15:0] span;
    logic [1:0]  aosel;
    logic        byp_run;
    logic [32:0] byp_cnt;
    logic [6:0]  byp_min;
    logic [31:0] hold_cnt;
    logic        fs_act;
    logic [1:0]  latched;
    dar_chs_t    ch1;
    dar_chs_t    ch2;
    logic [31:0] rdata;
    dar_out_t    out;
  } dar_state_t;
  dar_state_t s_q;
  dar_state_t s_d;
  // Condition with clear-side hysteresis
  function automatic logic cond_f(input logic [15:0] rd, input logic [15:0] sp,
                                  input logic [15:0] hy, input logic below,
                                  input logic active);
    logic [16:0] lo, hi;
    lo = {1'b0, sp} - {1'b0, hy};
    hi = {1'b0, sp} + {1'b0, hy};
    if (!below)
      cond_f = active ? ({1'b0, rd} > lo) : (rd > sp);
    else
      cond_f = active ? ({1'b0, rd} < hi) : (rd < sp);
  endfunction
  // Delay channel: one-minute ticks, restart on drop
  function automatic dar_chs_t chan_f(input dar_chs_t c, input logic cnd,
                                      input logic [8:0] dly, input logic hold);
    dar_chs_t n;
    n = c;
    case (c.st)
      DAR_IDLE:
      begin
        n.cnt  = '0;
        n.mins = '0;
        if (cnd && !hold)
          n.st = (dly == 9'h000) ? DAR_ALARM : DAR_WAIT;
      end
      DAR_WAIT:
      begin
        if (!cnd || hold)
          n.st = DAR_IDLE;
        else if (c.cnt == 33'(MIN_CYCLES - 1))
        begin
          n.cnt  = '0;
          n.mins = c.mins + 9'h001;
          if (c.mins + 9'h001 >= dly)
            n.st = DAR_ALARM;
        end
        else
          n.cnt = c.cnt + 33'h1;
      end
      DAR_ALARM:
      begin
        if (!cnd || hold)
          n.st = DAR_IDLE;
      end
      default: n.st = DAR_IDLE;
    endcase
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic        a_sel;
  logic        trig1;
  logic        trig2;
  logic [15:0] hyst;
  logic [15:0] mid;
  logic [15:0] wv;
  logic [16:0] sum;
  assign a_sel     = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_q.rdata;
  assign pins_o    = s_q.out;
  assign hyst      = s_q.range / 16'd100;
  assign sum       = {1'b0, s_q.zero} + {1'b0, s_q.span};
  assign mid       = sum[16:1];
  assign wv        = hwdata[15:0];
  // Trigger reported by channel or failsafe
  assign trig1     = (s_q.ch1.st == DAR_ALARM) || s_q.latched[0] || s_q.fs_act;
  assign trig2     = (s_q.ch2.st == DAR_ALARM) || s_q.latched[1] || s_q.fs_act;

  always_comb
  begin
    logic c1, c2, rel;
    logic [1:0] on;
    c1  = 1'b0;
    c2  = 1'b0;
    rel = 1'b0;
    on  = 2'b00;
    s_d = s_q;
    s_d.wr_pend = a_sel && hwrite;
    s_d.wr_addr = haddr[7:0];
    // Register write in data phase
    if (s_q.wr_pend)
    begin
      case (s_q.wr_addr)
        OFS_CTRL:  s_d.ctrl = hwdata[5:0];
        OFS_RANGE: s_d.range = wv;
        OFS_SP1:   if (wv <= s_q.range) s_d.sp1 = wv;
        OFS_SP2:   if (wv <= s_q.range) s_d.sp2 = wv;
        OFS_DLY1:  if (hwdata[8:0] <= 9'(DELAY_MAX_MIN)) s_d.dly1 = hwdata[8:0];
        OFS_DLY2:  if (hwdata[8:0] <= 9'(DELAY_MAX_MIN)) s_d.dly2 = hwdata[8:0];
        OFS_BYP:
        begin
          if (hwdata[6:0] <= 7'(BYP_MAX_MIN))
          begin
            s_d.byp     = hwdata[6:0];
            s_d.byp_run = (hwdata[6:0] != 7'h00);
            s_d.byp_cnt = '0;
            s_d.byp_min = '0;
          end
        end
        OFS_ZERO:  s_d.zero = wv;
        OFS_SPAN:  s_d.span = wv;
        OFS_AOCMD:
        begin
          s_d.aosel = hwdata[1:0];
          if (hwdata[1:0] == AO_ZERO && hwdata[AO_UP])
            s_d.zero = s_q.zero + 16'h0001;
          else if (hwdata[1:0] == AO_ZERO && hwdata[AO_DN])
            s_d.zero = s_q.zero - 16'h0001;
          if (hwdata[1:0] == AO_SPAN && hwdata[AO_UP])
            s_d.span = s_q.span + 16'h0001;
          else if (hwdata[1:0] == AO_SPAN && hwdata[AO_DN])
            s_d.span = s_q.span - 16'h0001;
        end
        default: ;
      endcase
    end
    if (s_q.byp_run && !(s_q.wr_pend && s_q.wr_addr == OFS_BYP))
    begin
      if (s_q.byp_cnt == 33'(MIN_CYCLES - 1))
      begin
        s_d.byp_cnt = '0;
        s_d.byp_min = s_q.byp_min + 7'h01;
        if (s_q.byp_min + 7'h01 >= s_q.byp)
          s_d.byp_run = 1'b0;
      end
      else
        s_d.byp_cnt = s_q.byp_cnt + 33'h1;
    end
    c1 = cond_f(pins_i.reading, s_q.sp1, hyst, s_q.ctrl[CTRL_BELOW1],
                s_q.ch1.st == DAR_ALARM);
    c2 = cond_f(pins_i.reading, s_q.sp2, hyst, s_q.ctrl[CTRL_BELOW2],
                s_q.ch2.st == DAR_ALARM);
    s_d.ch1 = chan_f(s_q.ch1, c1, s_q.dly1, s_q.byp_run);
    s_d.ch2 = chan_f(s_q.ch2, c2, s_q.dly2, s_q.byp_run);
    if (pins_i.holdoff_btn)
    begin
      if (s_q.hold_cnt < HOLD_CYCLES - 1)
        s_d.hold_cnt = s_q.hold_cnt + 32'h1;
      else
        rel = 1'b1;
    end
    else
      s_d.hold_cnt = '0;
    if (s_q.ctrl[CTRL_LATCH] && !s_q.byp_run)
    begin
      if (s_q.ch1.st == DAR_ALARM)
        s_d.latched[0] = 1'b1;
      else if (rel)
        s_d.latched[0] = 1'b0;
      if (s_q.ch2.st == DAR_ALARM)
        s_d.latched[1] = 1'b1;
      else if (rel)
        s_d.latched[1] = 1'b0;
    end
    else
      s_d.latched = 2'b00;
    // Failsafe low supply, hold to 12V, ignore if off
    if (!s_q.ctrl[CTRL_FSAFE])
      s_d.fs_act = 1'b0;
    else if (pins_i.supply_low)
      s_d.fs_act = 1'b1;
    else if (pins_i.supply_ok)
      s_d.fs_act = 1'b0;
    on = {trig2, trig1};
    s_d.out.flag  = on;
    s_d.out.relay = on ^ {s_q.ctrl[CTRL_OPEN2], s_q.ctrl[CTRL_OPEN1]};
    // Analog output; in measure mode bypass freezes it at the zero point
    case (s_q.aosel)
      AO_ZERO: s_d.out.ao_code = s_q.zero;
      AO_SPAN: s_d.out.ao_code = s_q.span;
      AO_MID:  s_d.out.ao_code = mid;
      default: if (!s_q.byp_run) s_d.out.ao_code = pins_i.reading;
    endcase
    if (s_q.byp_run && s_q.aosel == AO_MEAS)
      s_d.out.ao_code = s_q.zero;
    // Read data for the next data phase
    s_d.rdata = '0;
    if (a_sel && !hwrite)
    begin
      case (haddr[7:0])
        OFS_CTRL:   s_d.rdata = {26'h0, s_q.ctrl};
        OFS_RANGE:  s_d.rdata = {16'h0, s_q.range};
        OFS_SP1:    s_d.rdata = {16'h0, s_q.sp1};
        OFS_SP2:    s_d.rdata = {16'h0, s_q.sp2};
        OFS_DLY1:   s_d.rdata = {23'h0, s_q.dly1};
        OFS_DLY2:   s_d.rdata = {23'h0, s_q.dly2};
        OFS_BYP:    s_d.rdata = {25'h0, s_q.byp};
        OFS_ZERO:   s_d.rdata = {16'h0, s_q.zero};
        OFS_SPAN:   s_d.rdata = {16'h0, s_q.span};
        OFS_AOCMD:  s_d.rdata = {30'h0, s_q.aosel};
        OFS_STATUS: s_d.rdata = {28'h0, s_q.fs_act, s_q.byp_run, trig2, trig1};
        OFS_READ:   s_d.rdata = {16'h0, pins_i.reading};
        default:    s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q       <= '0;
      s_q.range <= RST_RANGE;
      s_q.zero  <= RST_ZERO;
      s_q.span  <= RST_SPAN;
    end
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_sp_reject;
    @(posedge clk) disable iff (!rst_n)
      (s_q.wr_pend && s_q.wr_addr == OFS_SP1 && hwdata[15:0] > s_q.range)
      |=> $stable(s_q.sp1);
  endproperty
  a_sp_reject: assert property (p_sp_reject) else $error("setpoint over range taken");
  property p_bypass_quiet;
    @(posedge clk) disable iff (!rst_n)
      s_q.byp_run |=> (s_q.ch1.st == DAR_IDLE && s_q.ch2.st == DAR_IDLE);
  endproperty
  a_bypass_quiet: assert property (p_bypass_quiet) else $error("alarm during bypass");
  property p_zero_delay;
    @(posedge clk) disable iff (!rst_n)
      (s_q.ch1.st == DAR_IDLE && s_q.dly1 == 9'h000 && !s_q.byp_run
       && cond_f(pins_i.reading, s_q.sp1, hyst, s_q.ctrl[CTRL_BELOW1], 1'b0))
      |=> s_q.ch1.st == DAR_ALARM;
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero delay not immediate");
  sequence s_idle_then_clear;
    s_q.ch1.st == DAR_IDLE ##1 s_q.ch1.cnt == 33'h0;
  endsequence
  property p_restart;
    @(posedge clk) disable iff (!rst_n)
      (s_q.ch1.st == DAR_WAIT && !cond_f(pins_i.reading, s_q.sp1, hyst,
       s_q.ctrl[CTRL_BELOW1], 1'b0)) |=> s_idle_then_clear;
  endproperty
  a_restart: assert property (p_restart) else $error("delay not restarted");
  property p_status;
    @(posedge clk) disable iff (!rst_n)
      s_q.ch2.st == DAR_ALARM |=> s_q.out.flag[1];
  endproperty
  a_status: assert property (p_status) else $error("status not on");
  property p_sense;
    @(posedge clk) disable iff (!rst_n)
      ##1 (s_q.out.relay[0] == (s_q.out.flag[0] ^ $past(s_q.ctrl[CTRL_OPEN1])));
  endproperty
  a_sense: assert property (p_sense) else $error("contact sense wrong");
  sequence s_fs_then_flags;
    s_q.fs_act ##1 s_q.out.flag == 2'b11;
  endsequence
  property p_failsafe;
    @(posedge clk) disable iff (!rst_n)
      (s_q.ctrl[CTRL_FSAFE] && pins_i.supply_low) |=> s_fs_then_flags;
  endproperty
  a_failsafe: assert property (p_failsafe) else $error("failsafe missed");
  property p_nofs;
    @(posedge clk) disable iff (!rst_n)
      !s_q.ctrl[CTRL_FSAFE] |=> !s_q.fs_act;
  endproperty
  a_nofs: assert property (p_nofs) else $error("supply trip without failsafe");
  property p_mid;
    @(posedge clk) disable iff (!rst_n)
      s_q.aosel == AO_MID && $stable(s_q.aosel) && $stable(mid) |=> s_q.out.ao_code == $past(mid);
  endproperty
  a_mid: assert property (p_mid) else $error("midpoint wrong");

endmodule
`default_nettype wire

// [dar_pkg.sv]
// Purpose: Shared constants and types for the dual alarm relay logic
// Assumes: 100 MHz clock, AHB-Lite register access
// Notes:   Offsets are byte addresses of aligned 32-bit words
package dar_pkg;

  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned MINUTE_S      = 60;
  localparam int unsigned HOLD_MS       = 1000;
  localparam int unsigned HOLD_CYC      = CLK_HZ / 1000 * HOLD_MS;
  // A minute at full rate is six thousand million cycles, past 32 bits
  localparam longint unsigned MIN_CYC   = longint'(CLK_HZ) * MINUTE_S;
  localparam int unsigned DELAY_MAX_MIN = 300;
  localparam int unsigned BYP_MAX_MIN   = 120;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_RANGE  = 8'h04;
  localparam logic [7:0] OFS_SP1    = 8'h08;
  localparam logic [7:0] OFS_SP2    = 8'h0c;
  localparam logic [7:0] OFS_DLY1   = 8'h10;
  localparam logic [7:0] OFS_DLY2   = 8'h14;
  localparam logic [7:0] OFS_BYP    = 8'h18;
  localparam logic [7:0] OFS_ZERO   = 8'h1c;
  localparam logic [7:0] OFS_SPAN   = 8'h20;
  localparam logic [7:0] OFS_AOCMD  = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_READ   = 8'h2c;

  // CTRL field positions
  localparam int unsigned CTRL_OPEN1  = 0;
  localparam int unsigned CTRL_OPEN2  = 1;
  localparam int unsigned CTRL_BELOW1 = 2;
  localparam int unsigned CTRL_BELOW2 = 3;
  localparam int unsigned CTRL_LATCH  = 4;
  localparam int unsigned CTRL_FSAFE  = 5;

  // AOCMD codes; bit 4 steps up, bit 5 steps down the selected word
  localparam logic [1:0] AO_MEAS = 2'h0;
  localparam logic [1:0] AO_ZERO = 2'h1;
  localparam logic [1:0] AO_SPAN = 2'h2;
  localparam logic [1:0] AO_MID  = 2'h3;
  localparam int unsigned AO_UP  = 4;
  localparam int unsigned AO_DN  = 5;

  // Reset values
  localparam logic [15:0] RST_RANGE = 16'hffff;
  localparam logic [15:0] RST_ZERO  = 16'h0286;
  localparam logic [15:0] RST_SPAN  = 16'h0cb0;

  typedef enum logic [1:0] {
    DAR_IDLE  = 2'b00,
    DAR_WAIT  = 2'b01,
    DAR_ALARM = 2'b11
  } dar_ch_t;

  typedef struct packed {
    dar_ch_t     st;
    logic [32:0] cnt;
    logic [8:0]  mins;
  } dar_chs_t;

  typedef struct packed {
    logic [15:0] reading;
    logic        supply_low;
    logic        supply_ok;
    logic        holdoff_btn;
  } dar_in_t;

  typedef struct packed {
    logic [1:0]  relay;
    logic [1:0]  flag;
    logic [15:0] ao_code;
  } dar_out_t;

endpackage

// [dar_loop_rx.sv]
// Purpose: Far-side model of the relay contacts and the analog loop receiver
// Assumes: Contacts and loop settle within one clock
// Notes:   Registers what it sees, one cycle behind, as a slow field device would
`timescale 1ns/1ns
`default_nettype none
module dar_loop_rx
  import dar_pkg::*;
(
  input  wire logic              clk,
  input  wire dar_pkg::dar_out_t pins_o,
  output logic [1:0]             contact,
  output logic [15:0]            ao_seen
);
  always_ff @(posedge clk)
  begin
    contact <= pins_o.relay;
    ao_seen <= pins_o.ao_code;
  end
endmodule
`default_nettype wire

// [test_dual_alarm_relay_logic.sv]
// Purpose: Self-checking bench for the dual alarm relay logic
// Assumes: Minute and hold counts shortened through parameters
// Notes:   Read data checked by a monitor from a queue of expected values
`timescale 1ns/1ns
`default_nettype none
module test_dual_alarm_relay_logic;
  import dar_pkg::*;
  localparam int unsigned MINC  = 10;
  localparam int unsigned HOLDC = 5;
  logic        clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  dar_in_t     pi;
  dar_out_t    po;
  logic [1:0]  contact;
  logic [15:0] ao_seen;
  logic        rd_ph;
  logic [39:0] exp_q[$];
  logic [39:0] note;
  logic [1:0]  opn;
  logic [15:0] z;
  logic [15:0] s;
  int          failures;
  int          tests_run;
  int          seed;

  dar_top #(.MIN_CYCLES(MINC), .HOLD_CYCLES(HOLDC)) i_dut (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins_i(pi), .pins_o(po));

  dar_loop_rx i_rx (.clk(clk), .pins_o(po), .contact(contact), .ao_seen(ao_seen));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Holds the address phase, then the data phase, each until hready is seen high
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph  <= !wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd_ph  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back({a, e});
    bus(1'b0, a, 32'h0);
  endtask

  task automatic setctl(input logic [31:0] c);
    wr(OFS_CTRL, c);
    opn = c[1:0];
  endtask

  task automatic setin(input logic [15:0] r, input logic lo, input logic ok, input logic b);
    @(posedge clk);
    pi <= '{reading: r, supply_low: lo, supply_ok: ok, holdoff_btn: b};
  endtask

  // Contact follows the flag, inverted where the open-on-alarm sense is chosen
  task automatic pins(input logic [1:0] fl);
    // Third cycle lets the far-side model register the contacts
    cyc(3);
    @(negedge clk);
    check("flag", {30'h0, po.flag}, {30'h0, fl});
    check("contact", {30'h0, contact}, {30'h0, fl ^ opn});
  endtask

  task automatic ao(input logic [15:0] e);
    cyc(3);
    @(negedge clk);
    check("ao_code", {16'h0, ao_seen}, {16'h0, e});
  endtask

  always @(posedge clk)
  begin
    if (rd_ph === 1'b1 && hreadyout === 1'b1 && exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      check($sformatf("read %h", note[39:32]), hrdata, note[31:0]);
    end
  end

  // Whole sequence needs a few hundred cycles; this is far beyond it
  initial
  begin
    cyc(20000);
    failures++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed   = 32'h9428311d;
    rst_n  = 1'b0;
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
    pi     = '0;
    rd_ph  = 1'b0;
    opn    = 2'h0;
    z      = RST_ZERO;
    s      = RST_SPAN;
    cyc(5);
    rst_n <= 1'b1;
    rd(OFS_RANGE, {16'h0, RST_RANGE});
    rd(OFS_ZERO, {16'h0, RST_ZERO});
    rd(OFS_SPAN, {16'h0, RST_SPAN});
    rd(8'h30, 32'h0);
    rd(OFS_STATUS, 32'h0);
    check("hresp", {31'h0, hresp}, 32'h0);
    wr(OFS_RANGE, 32'd1000);
    wr(OFS_SP1, 32'd500);
    wr(OFS_SP2, 32'd700);
    wr(OFS_SP1, 32'd2000);
    rd(OFS_SP1, 32'd500);
    wr(OFS_DLY1, 32'd301);
    rd(OFS_DLY1, 32'd0);
    wr(OFS_BYP, 32'd121);
    rd(OFS_STATUS, 32'h0);
    // Above, first contact opens on alarm, no latch
    setctl(32'h01);
    setin(16'd600 + 16'($random(seed) & 32'h3f), 1'b0, 1'b0, 1'b0);
    pins(2'b01);
    rd(OFS_STATUS, 32'h1);
    setin(16'd495, 1'b0, 1'b0, 1'b0);
    pins(2'b01);
    setin(16'd480, 1'b0, 1'b0, 1'b0);
    pins(2'b00);
    setin(16'd750, 1'b0, 1'b0, 1'b0);
    pins(2'b11);
    setctl(32'h08);
    setin(16'd100, 1'b0, 1'b0, 1'b0);
    pins(2'b10);
    // Delay of two minutes, broken once midway
    setctl(32'h00);
    wr(OFS_DLY1, 32'd2);
    setin(16'd300, 1'b0, 1'b0, 1'b0);
    cyc(2);
    setin(16'd600, 1'b0, 1'b0, 1'b0);
    pins(2'b00);
    cyc(10);
    setin(16'd300, 1'b0, 1'b0, 1'b0);
    cyc(3);
    setin(16'd600, 1'b0, 1'b0, 1'b0);
    cyc(12);
    pins(2'b00);
    cyc(10);
    pins(2'b01);
    setin(16'd300, 1'b0, 1'b0, 1'b0);
    wr(OFS_DLY1, 32'd0);
    // Latching, short press ignored, long press releases
    setctl(32'h10);
    setin(16'd600, 1'b0, 1'b0, 1'b0);
    pins(2'b01);
    setin(16'd300, 1'b0, 1'b0, 1'b0);
    pins(2'b01);
    setin(16'd300, 1'b0, 1'b0, 1'b1);
    cyc(2);
    setin(16'd300, 1'b0, 1'b0, 1'b0);
    pins(2'b01);
    setin(16'd300, 1'b0, 1'b0, 1'b1);
    cyc(HOLDC + 3);
    setin(16'd300, 1'b0, 1'b0, 1'b0);
    pins(2'b00);
    // Failsafe sets on low supply, holds until supply is good
    setctl(32'h20);
    setin(16'd300, 1'b1, 1'b0, 1'b0);
    pins(2'b11);
    rd(OFS_STATUS, 32'hb);
    setin(16'd300, 1'b0, 1'b0, 1'b0);
    pins(2'b11);
    setin(16'd300, 1'b0, 1'b1, 1'b0);
    pins(2'b00);
    setctl(32'h00);
    setin(16'd300, 1'b1, 1'b0, 1'b0);
    pins(2'b00);
    // Shared bypass holds both alarms and parks the output at the zero word
    wr(OFS_AOCMD, {30'h0, AO_MEAS});
    wr(OFS_BYP, 32'd2);
    setin(16'd750, 1'b0, 1'b0, 1'b0);
    pins(2'b00);
    check("ao_code", {16'h0, po.ao_code}, {16'h0, z});
    rd(OFS_STATUS, 32'h4);
    cyc(2 * MINC + 4);
    pins(2'b11);
    setin(16'd300, 1'b0, 1'b0, 1'b0);
    // Output test points and steps of the calibration words
    for (int k = 1; k < 4; k++)
    begin
      wr(OFS_AOCMD, 32'(k));
      ao(k == 1 ? z : (k == 2 ? s : 16'((17'(z) + 17'(s)) >> 1)));
    end
    wr(OFS_AOCMD, 32'h11);
    z = z + 16'h1;
    rd(OFS_ZERO, {16'h0, z});
    ao(z);
    wr(OFS_AOCMD, 32'h22);
    s = s - 16'h1;
    rd(OFS_SPAN, {16'h0, s});
    ao(s);
    wr(OFS_ZERO, 32'd600);
    wr(OFS_SPAN, 32'd3400);
    wr(OFS_AOCMD, {30'h0, AO_MID});
    ao(16'd2000);
    wr(OFS_AOCMD, {30'h0, AO_MEAS});
    cyc(4);
    tally_and_finish();
  end
endmodule
`default_nettype wire
